// ==== rtl/wps_power_ctrl.v ====
`timescale 1ns/1ps
`include "wps_defines.vh"

module wps_power_ctrl #(
	parameter CNT_W = 12
) (
	// clock, reset, enable
	input  wire mclk,
	input  wire rst,
	input  wire clk_en,
	// pins from the host
	input  wire chip_reset_low,
	input  wire wake_request_pin,
	input  wire host_port_select,
	input  wire low_power_clock_in,
	// firmware status
	input  wire power_save_en,
	input  wire associated,
	input  wire traffic_pending,
	input  wire xo_must_run,
	input  wire snooze_pref,
	// outputs
	output reg  [2:0] power_state,
	output reg        crystal_oscillator_en,
	output reg        host_if_en,
	output reg        host_accept,
	output reg        host_if_sdio,
	output reg        core_reset,
	output reg        low_power_clock_in_present
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

reg [1:0] rstn_sync_q;
reg [1:0] wake_sync_q;
reg [1:0] sel_sync_q;
reg [1:0] lpc_sync_q;
reg       lpc_prev_q;
reg       rstn_prev_q;

// two flops on every pin before any logic reads it
always @(posedge mclk) begin
	if (rst) begin
		rstn_sync_q <= 2'h0;
		wake_sync_q <= 2'h0;
		sel_sync_q  <= 2'h0;
		lpc_sync_q  <= 2'h0;
		lpc_prev_q  <= 1'b0;
		rstn_prev_q <= 1'b0;
	end else if (clk_en) begin
		rstn_sync_q <= {rstn_sync_q[0], chip_reset_low};
		wake_sync_q <= {wake_sync_q[0], wake_request_pin};
		sel_sync_q  <= {sel_sync_q[0], host_port_select};
		lpc_sync_q  <= {lpc_sync_q[0], low_power_clock_in};
		lpc_prev_q  <= lpc_sync_q[1];
		rstn_prev_q <= rstn_sync_q[1];
	end
end

wire rstn_s    = rstn_sync_q[1];
wire wake_s    = wake_sync_q[1];
wire lpc_rise  = lpc_sync_q[1] & ~lpc_prev_q;
wire rstn_rise = rstn_s & ~rstn_prev_q;

////////////////////////////////////////////////////////////////////////////////
// low-power clock detector

reg [CNT_W-1:0] lpc_cnt_q;

// a stuck pin (tied to ground when unused) times out as absent
// the counter saturates at the limit so it cannot wrap into a false present;
// an edge in the same cycle as the timeout wins, keeping the clock present.
// limitation: a clock far below nominal is reported absent, which only
// costs power (oscillator kept on), never a missed wake-up
always @(posedge mclk) begin
	if (rst) begin
		lpc_cnt_q      <= {CNT_W{1'b0}};
		low_power_clock_in_present <= 1'b0;
	end else if (clk_en) begin
		if (lpc_rise) begin
			lpc_cnt_q      <= {CNT_W{1'b0}};
			low_power_clock_in_present <= 1'b1;
		end else if (lpc_cnt_q == `WPS_LPCLK_TIMEOUT) begin
			low_power_clock_in_present <= 1'b0;
		end else begin
			lpc_cnt_q <= lpc_cnt_q + 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// power state machine

reg [2:0]       state_q;
reg [CNT_W-1:0] tmr_q;

// idle means nothing to send and, when not associated, no host wake request
// wake request is checked again in may_sleep because the host keeps it
// low whenever sleep is allowed; a high level always keeps us awake.
// deep sleep is preferred when possible, since it saves the most power
wire idle      = ~traffic_pending & (associated | ~wake_s);
wire may_sleep = power_save_en & idle & ~wake_s;
wire use_deep  = low_power_clock_in_present & ~xo_must_run;

always @(posedge mclk) begin
	if (rst) begin
		state_q <= `WPS_ST_RESET;
		tmr_q   <= {CNT_W{1'b0}};
	end else if (clk_en) begin
		if (!rstn_s) begin
			// held in reset whatever else happens
			state_q <= `WPS_ST_RESET;
			tmr_q   <= {CNT_W{1'b0}};
		end else begin
			case (state_q)
				`WPS_ST_RESET: begin
					// full start-up only on the release edge
					if (rstn_rise) begin
						state_q <= `WPS_ST_WAKE;
						tmr_q   <= {CNT_W{1'b0}};
					end
				end
				`WPS_ST_LISTEN: begin
					if (tmr_q != `WPS_LISTEN_CYC)
						tmr_q <= tmr_q + 1'b1;
					// stays listening unless power save allows otherwise
					if (may_sleep && tmr_q == `WPS_LISTEN_CYC) begin
						tmr_q <= {CNT_W{1'b0}};
						if (use_deep)
							state_q <= `WPS_ST_DEEP;
						else if (snooze_pref && !low_power_clock_in_present && !xo_must_run)
							state_q <= `WPS_ST_SNOOZE;
						else
							state_q <= `WPS_ST_SLEEP_XO;
					end
				end
				`WPS_ST_DEEP, `WPS_ST_SLEEP_XO, `WPS_ST_SNOOZE: begin
					// beacon wake counted on low-power clock edges
					if (lpc_rise)
						tmr_q <= tmr_q + 1'b1;
					if (wake_s || traffic_pending || !power_save_en ||
					    (lpc_rise && tmr_q == `WPS_BEACON_TICKS - 1'b1) ||
					    (state_q != `WPS_ST_DEEP && tmr_q == `WPS_BEACON_TICKS)) begin
						// oscillator must settle before host port opens
						state_q <= (state_q == `WPS_ST_DEEP) ? `WPS_ST_WAKE
						                                      : `WPS_ST_LISTEN;
						tmr_q   <= {CNT_W{1'b0}};
					end
				end
				`WPS_ST_WAKE: begin
					if (tmr_q == `WPS_XO_SETTLE) begin
						state_q <= `WPS_ST_LISTEN;
						tmr_q   <= {CNT_W{1'b0}};
					end else begin
						tmr_q <= tmr_q + 1'b1;
					end
				end
				default: begin
					state_q <= `WPS_ST_RESET;
					tmr_q   <= {CNT_W{1'b0}};
				end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// registered outputs

// host port select is caught on the reset release edge only
always @(posedge mclk) begin
	if (rst) begin
		host_if_sdio <= 1'b0;
	end else if (clk_en && rstn_rise) begin
		host_if_sdio <= sel_sync_q[1];
	end
end

// outputs follow the state one cycle later
// all outputs in this block come from the same registered state, so they never disagree;
// the price is one extra cycle between a state change and the pins
always @(posedge mclk) begin
	if (rst) begin
		power_state           <= `WPS_ST_RESET;
		crystal_oscillator_en <= 1'b0;
		host_if_en            <= 1'b0;
		host_accept           <= 1'b0;
		core_reset            <= 1'b1;
	end else if (clk_en) begin
		power_state           <= state_q;
		// oscillator off only in deep sleep and reset
		crystal_oscillator_en <= (state_q != `WPS_ST_DEEP) &&
		                         (state_q != `WPS_ST_RESET);
		host_if_en            <= (state_q != `WPS_ST_DEEP) &&
		                         (state_q != `WPS_ST_RESET);
		// host traffic only once the oscillator has settled
		host_accept           <= (state_q == `WPS_ST_LISTEN) ||
		                         (state_q == `WPS_ST_SLEEP_XO) ||
		                         (state_q == `WPS_ST_SNOOZE);
		core_reset            <= (state_q == `WPS_ST_RESET);
	end
end

endmodule // wps_power_ctrl

// ==== rtl/wps_defines.vh ====
`ifndef WPS_DEFINES_VH
`define WPS_DEFINES_VH

// power states
`define WPS_ST_RESET     3'h0
`define WPS_ST_LISTEN    3'h1
`define WPS_ST_DEEP      3'h2
`define WPS_ST_SLEEP_XO  3'h3
`define WPS_ST_SNOOZE    3'h4
`define WPS_ST_WAKE      3'h5

// low-power clock presence: edges must come within this many mclk cycles
// 32.768 kHz period is about 1526 cycles at 50 MHz; allow twice that
`define WPS_LPCLK_TIMEOUT 12'h0_BEC
// oscillator restart settle time before host interface is usable
`define WPS_XO_SETTLE     12'h0_040
// beacon interval, counted in low-power clock edges
`define WPS_BEACON_TICKS  12'h0_0C8
// beacon listen window, mclk cycles
`define WPS_LISTEN_CYC    12'h0_100

`endif

// ==== verification/wps_host_model.sv ====
`timescale 1ns/1ps
// host side: pulled-up reset pin, select pin reused as data, 32 kHz clock
module wps_host_model (
	input wire mclk,
	input wire rst_drive,
	input wire wake,
	input wire sel,
	input wire lp_run,
	output wire chip_reset_low,
	output wire wake_request_pin,
	output wire host_port_select,
	output reg low_power_clock_in
);
	reg [9:0] n_q = 10'h000;
	reg [3:0] h_q = 4'h0;
	initial low_power_clock_in = 1'b0;
	assign chip_reset_low = !rst_drive;
	assign wake_request_pin = wake;
	// select holds 8 cycles past release, then toggles as a data line would
	assign host_port_select = (h_q < 4'h8) ? sel : n_q[0];
	always @(posedge mclk) begin
		h_q <= rst_drive ? 4'h0 : h_q + {3'h0, h_q != 4'hf};
		n_q <= (n_q == 10'h2fa) ? 10'h000 : n_q + 10'h001;
		if (lp_run && n_q == 10'h2fa)
			low_power_clock_in <= !low_power_clock_in;
	end
endmodule // wps_host_model

// ==== verification/wps_power_ctrl_sva.sv ====
`timescale 1ns/1ps
`include "wps_defines.vh"
module wps_power_ctrl_sva (
	input wire mclk, rst, clk_en, chip_reset_low, wake_request_pin, power_save_en, xo_must_run,
	input wire [2:0] power_state,
	input wire crystal_oscillator_en, host_if_en, host_accept, low_power_clock_in_present, core_reset
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// outputs follow the state one cycle late
	rst_state_a: assert property (disable iff (1'b0) rst && clk_en |=> power_state == 3'h0 && core_reset)
		else $error("no reset state");
	pin_rst_a: assert property ((!chip_reset_low && clk_en)[*4] |=> power_state == `WPS_ST_RESET)
		else $error("pin reset ignored");
	// power_state and the enables are registered from the same state, so they agree in one cycle
	deep_off_a: assert property (power_state == `WPS_ST_DEEP |-> !crystal_oscillator_en && !host_if_en)
		else $error("deep sleep left power on");
	xo_on_a: assert property (power_state inside {3'h3, 3'h4} |-> crystal_oscillator_en)
		else $error("oscillator off");
	no_accept_a: assert property (power_state inside {3'h2, 3'h5} |-> !host_accept)
		else $error("host accepted early");
	listen_stay_a: assert property (power_state == 3'h1 && !power_save_en |=> power_state < 3'h2)
		else $error("slept without power save");
	wake_hold_a: assert property (wake_request_pin[*5] ##0 power_state == 3'h1 |=> power_state < 3'h2)
		else $error("slept with wake high");
	// the entry decision was taken two edges before deep shows on the output
	deep_entry_a: assert property (power_state == 3'h1 ##1 power_state == 3'h2 |-> $past(low_power_clock_in_present, 2) && !$past(xo_must_run, 2))
		else $error("bad deep entry");
	cover property (power_state == `WPS_ST_DEEP);
	cover property (power_state == `WPS_ST_SNOOZE);
	cover property (power_state == `WPS_ST_SLEEP_XO);
endmodule // wps_power_ctrl_sva
bind wps_power_ctrl wps_power_ctrl_sva wps_power_ctrl_sva_i (.*);

// ==== verification/test_wlan_power_state_control.sv ====
`timescale 1ns/1ps
`include "wps_defines.vh"
module test_wlan_power_state_control;
	reg mclk = 0, rst = 1, clk_en = 1, associated = 1, traffic_pending = 0, power_save_en = 0;
	reg xo_must_run = 0, snooze_pref = 0, rst_drive = 1, wake = 0, sel = 1, lp_run = 1;
	wire chip_reset_low, wake_request_pin, host_port_select, low_power_clock_in, host_if_sdio;
	wire crystal_oscillator_en, host_if_en, host_accept, core_reset, low_power_clock_in_present;
	wire [2:0] power_state;
	integer n_errors = 0, tests_run = 0, cyc = 0, i, k;
	reg [6:0] rows [0:5]; // power save, xo, snooze, lp clock, expected state
	wps_power_ctrl wps_power_ctrl_i (.*);
	wps_host_model wps_host_model_i (.*);
	always #10 mclk = ~mclk;
	// cut a hang short
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			n_errors = n_errors + 1;
			close_out;
		end
	end
	task step(input integer n);
		begin repeat (n) @(posedge mclk); #1; end
	endtask
	task check(input [63:0] name, input [2:0] seen, input [2:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("ERROR %s exp %h seen %h", name, exp, seen);
			end
		end
	endtask
	task close_out;
		begin
			$display("errors %0d checks %0d", n_errors, tests_run);
			if (n_errors == 0 && tests_run > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task pin_reset(input s);
		begin
			rst_drive = 1;
			sel = s;
			step(10);
			check("core", core_reset, 1'b1);
			rst_drive = 0;
			step(80);
			check("sdio", host_if_sdio, s);
			check("restart", power_state, `WPS_ST_LISTEN);
		end
	endtask
	initial begin
		rows[0] = {4'h1, `WPS_ST_LISTEN};
		rows[1] = {4'h9, `WPS_ST_DEEP};
		rows[2] = {4'hd, `WPS_ST_SLEEP_XO};
		rows[3] = {4'hf, `WPS_ST_SLEEP_XO};
		rows[4] = {4'h8, `WPS_ST_SLEEP_XO};
		rows[5] = {4'ha, `WPS_ST_SNOOZE};
		step(20);
		rst = 0;
		step(1000);
		pin_reset(1'b1);
		// wake from deep sleep: host port usable only after the settle time
		power_save_en = 1;
		step(400);
		wake = 1;
		k = 0;
		while (host_accept !== 1'b1 && k < 200) begin step(1); k = k + 1; end
		check("settle", k > 60, 1'b1);
		check("port", {crystal_oscillator_en, host_if_en}, 3'h3);
		step(400);
		check("wakehold", power_state, `WPS_ST_LISTEN);
		wake = 0;
		for (i = 0; i < 6; i = i + 1) begin
			lp_run = rows[i][3];
			if (!lp_run) step(3100);
			{power_save_en, xo_must_run, snooze_pref} = rows[i][6:4];
			step(400);
			check("row", power_state, rows[i][2:0]);
			traffic_pending = 1;
			power_save_en = 0;
			step(100);
			traffic_pending = 0;
		end
		// clock enable low freezes the listen window, so no sleep may follow
		clk_en = 0;
		power_save_en = 1;
		step(300);
		check("freeze", power_state, `WPS_ST_LISTEN);
		clk_en = 1;
		step(400);
		pin_reset(1'b0);
		close_out;
	end
endmodule // test_wlan_power_state_control
